/* rtl/aol_map.svh */
// Constants and rule summary for the converter output latch block
// What this block does
// R1: Convert and latch only on encode rising edge
// R2: Result appears one encode cycle later
// R3: Data and flag come from registered latches
// R4: Enabled mode overrange: flag high, data low
// R5: Inhibited mode overrange: flag low, data high
// R6: Flag means overrange only when reporting enabled
// R7: In-range samples keep flag low always
// R8: In-range data is straight binary, bit0 LSB
`ifndef AOL_MAP_SVH
`define AOL_MAP_SVH
`define AOL_DATA_W     8
`define AOL_FIFO_DEPTH 8
`define AOL_ZERO8      8'h00
`define AOL_ONES8      8'hff
`endif

/* rtl/aol_pkg.sv */
// Types shared by the converter output latch block
`default_nettype none
package aol_pkg;
`include "aol_map.svh"
   typedef struct packed {
      logic                    over;
      logic [`AOL_DATA_W-1:0] code;
   } aol_sample_t;
   typedef struct packed {
      logic                    flag;
      logic [`AOL_DATA_W-1:0] bits;
   } aol_word_t;
endpackage
`default_nettype wire

/* rtl/aol_sync.sv */
// Two-flop synchroniser for a level from outside the clock domain
`default_nettype none
module aol_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage is read only by the second
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // aol_sync

/* rtl/aol_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module aol_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output var  logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output var  logic         out_valid,
   input  wire logic         out_ready,
   output var  logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   // Pointer wrap relies on a power-of-two depth
   if (D < 2 || (1 << AW) != D) begin : g_bad_depth
      $error("aol_fifo: D must be power of 2");
   end
   logic [W-1:0] mem_r [D];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;
   logic         push;
   logic         pop;

   // Full when pointers differ only in the wrap bit
   assign in_ready  = !((wp_r[AW] != rp_r[AW]) &&
                        (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid = (wp_r != rp_r);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_r[rp_r[AW-1:0]];

   // Storage writes
   always_ff @(posedge mclk) begin
      if (push) mem_r[wp_r[AW-1:0]] <= in_data;
   end

   // Pointers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop)  rp_r <= rp_r + 1'b1;
      end
   end
endmodule // aol_fifo

/* rtl/aol_top.sv */
// Output latch stage of an 8-bit flash converter with overrange coding
`default_nettype none
`include "aol_map.svh"
module aol_top
   import aol_pkg::*;
#(
   parameter int DATA_W = `AOL_DATA_W,
   parameter int DEPTH  = `AOL_FIFO_DEPTH
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic              encode_p,
   input  wire logic              encode_n,
   input  wire logic              sample_valid,
   output var  logic              sample_ready,
   input  wire aol_sample_t       sample_in,
   input  wire logic              ovr_enable,
   output var  logic [DATA_W-1:0] data_out,
   output var  logic              sample_bit_lsb,
   output var  logic              sample_bit_msb,
   output var  logic              overrange_out,
   output var  logic              latch_updated
);
   // The overrange codes are eight bits wide, so refuse other widths
   if (DATA_W != `AOL_DATA_W) begin : g_bad_width
      $error("aol_top: DATA_W must be 8");
   end

   logic        rst_s1_r;
   logic        rst_n_r;
   logic [1:0]  enc_s;
   logic        ovr_en_s;
   logic        enc_prev_r;
   logic        enc_rise;
   logic        enc_q_valid;
   logic        enc_q_ready;
   aol_sample_t enc_q;
   aol_word_t   conv_r;
   logic        conv_vld_r;
   aol_word_t   word_nxt;
   aol_word_t   out_r;
   logic        upd_r;

   // Reset release through two flops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Encode pair and mode pin come from pins, so synchronise them
   aol_sync #(.W(3)) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n_r),
      .d     ({encode_p, encode_n, ovr_enable}),
      .q     ({enc_s, ovr_en_s})
   );

   // Differential edge: true high and complement low
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) enc_prev_r <= 1'b0;
      else          enc_prev_r <= enc_s[1] & ~enc_s[0];
   end
   assign enc_rise = (enc_s[1] & ~enc_s[0]) & ~enc_prev_r; // R1

   // Comparator results wait here until an encode edge takes one
   aol_fifo #(.W($bits(aol_sample_t)), .D(DEPTH)) u_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n_r),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   (sample_in),
      .out_valid (enc_q_valid),
      .out_ready (enc_q_ready),
      .out_data  (enc_q)
   );
   // Stall drain except on edges; an empty queue repeats the last code
   assign enc_q_ready = enc_rise; // R1

   // Overrange coding picks polarity by mode; in-range is straight binary
   always_comb begin
      word_nxt = '0;
      if (enc_q.over) begin
         if (ovr_en_s) begin
            word_nxt.flag = 1'b1;        // R4 R6
            word_nxt.bits = `AOL_ZERO8;  // R4
         end else begin
            word_nxt.flag = 1'b0;        // R5
            word_nxt.bits = `AOL_ONES8;  // R5
         end
      end else begin
         word_nxt.flag = 1'b0;           // R7
         word_nxt.bits = enc_q.code;     // R8
      end
   end

   // Conversion stage: sampled on an encode edge
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         conv_r     <= '0;
         conv_vld_r <= 1'b0;
      end else if (enc_rise) begin      // R1
         if (enc_q_valid) conv_r <= word_nxt;
         conv_vld_r <= 1'b1;
      end
   end

   // Output latch: previous conversion moves out on the next edge
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         out_r <= '0;
         upd_r <= 1'b0;
      end else begin
         upd_r <= enc_rise & conv_vld_r;
         if (enc_rise) out_r <= conv_r; // R2 R3
      end
   end

   // Outputs come straight from latch flops and, except the latch_updated pulse, hold between edges
   assign data_out       = out_r.bits;               // R3
   assign sample_bit_lsb = out_r.bits[0];            // R8
   assign sample_bit_msb = out_r.bits[DATA_W-1];     // R8
   assign overrange_out  = out_r.flag;               // R3 R6
   assign latch_updated  = upd_r;
endmodule // aol_top
`default_nettype wire

/* dv/aol_properties.sv */
// Port-level assertions for the converter output latch stage
`default_nettype none
module aol_chk #(
   parameter int DATA_W = 8
) (
   input wire logic              mclk,
   input wire logic              nrst,
   input wire logic              encode_p,
   input wire logic              encode_n,
   input wire logic              ovr_enable,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              sample_bit_lsb,
   input wire logic              sample_bit_msb,
   input wire logic              overrange_out,
   input wire logic              latch_updated
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       hi_r;
   logic [5:0] h_r;
   wire        rise = encode_p & ~encode_n & ~hi_r;
   wire [8:0]  q = {overrange_out, data_out[7:0]};
   // Recent encode rises at the pins; the sync delay hides them a while
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hi_r <= 1'b0;
         h_r <= 6'h00;
      end else begin
         hi_r <= encode_p & ~encode_n;
         h_r <= {h_r[4:0], rise};
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_moved; $changed(q); endsequence
   a_out_on_encode: assert property (s_moved |-> h_r != 6'h00)
      else $error("outputs moved without an encode rise");
   a_upd_after_enc: assert property (latch_updated |-> h_r[2])
      else $error("update pulse not three cycles after a rise");
   a_upd_one_cycle: assert property (latch_updated |=> !latch_updated)
      else $error("update pulse too long");
   a_chg_then_upd: assert property (s_moved |-> latch_updated)
      else $error("no update pulse while outputs moved");
   a_latch_hold: assert property (s_moved |=> $stable(q)[*3])
      else $error("outputs not held between encode edges");
   a_rtz_zero: assert property (overrange_out |-> data_out[7:0] == 8'h00)
      else $error("flag high with nonzero data");
   a_flag_mode: assert property (overrange_out |-> ovr_enable)
      else $error("flag high while reporting inhibited");
   a_bit_map: assert property (sample_bit_lsb == data_out[0] &&
      sample_bit_msb == data_out[7])
      else $error("end bits differ from data word");
endmodule // aol_chk
bind aol_top aol_chk #(.DATA_W(DATA_W)) u_chk (.mclk(mclk), .nrst(nrst),
   .encode_p(encode_p), .encode_n(encode_n), .ovr_enable(ovr_enable),
   .data_out(data_out), .sample_bit_lsb(sample_bit_lsb),
   .sample_bit_msb(sample_bit_msb), .overrange_out(overrange_out),
   .latch_updated(latch_updated));
`default_nettype wire

/* dv/aol_cap.sv */
// Capture logic on the far side, taking each published word
`default_nettype none
module aol_cap
   import aol_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       latch_updated,
   input  wire logic [7:0] data_out,
   input  wire logic       overrange_out,
   output var  aol_word_t  cap_r,
   output var  logic [7:0] cnt_r
);
   timeunit 1ns;
   timeprecision 100ps;
   // Take on the pulse: the latches moved at the same edge as it rose
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cap_r <= '0;
         cnt_r <= 8'h00;
      end else if (latch_updated) begin
         cap_r <= {overrange_out, data_out};
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule // aol_cap
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the converter output latch stage
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import aol_pkg::*;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        enc_p = 1'b0;
   logic        enc_n = 1'b1;
   logic        s_valid = 1'b0;
   logic        ovr_en = 1'b0;
   aol_sample_t s_in = '0;
   logic        s_ready, lsb, msb, ovr, upd;
   logic [7:0]  dout, cnt;
   aol_word_t   cap;
   int          n_mismatch = 0;
   int          comparisons = 0;
   always #2 mclk = ~mclk;
   aol_top dut (.mclk(mclk), .nrst(nrst), .encode_p(enc_p), .encode_n(enc_n),
      .sample_valid(s_valid), .sample_ready(s_ready), .sample_in(s_in),
      .ovr_enable(ovr_en), .data_out(dout), .sample_bit_lsb(lsb),
      .sample_bit_msb(msb), .overrange_out(ovr), .latch_updated(upd));
   aol_cap u_cap (.mclk(mclk), .nrst(nrst), .latch_updated(upd),
      .data_out(dout), .overrange_out(ovr), .cap_r(cap), .cnt_r(cnt));
   task automatic chk(logic [8:0] got, logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge mclk);
   endtask
   // Hold valid until ready is seen high at a falling edge, then through the next rising edge
   task automatic push(aol_sample_t s);
      int k;
      k = 0;
      s_valid <= 1'b1;
      s_in <= s;
      do begin
         @(negedge mclk);
         k++;
      end while (s_ready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_mismatch++;
         conclude();
      end
      tick(1);
      s_valid <= 1'b0;
      // One idle cycle so back-to-back pushes never rewrite valid at once
      tick(1);
   endtask
   // Each pin level kept three cycles, above the two-cycle minimum
   task automatic enc();
      enc_p <= 1'b1;
      enc_n <= 1'b0;
      tick(3);
      enc_p <= 1'b0;
      enc_n <= 1'b1;
      tick(3);
   endtask
   task automatic conv(aol_sample_t s, logic m, logic [8:0] exp);
      logic [7:0] c0;
      ovr_en <= m;
      tick(4);
      c0 = cnt;
      push(s);
      enc();
      enc();
      chk(cnt - c0, 9'h002);
      chk(cap, exp);
      chk({ovr, dout}, exp);
      chk({7'h00, msb, lsb}, {7'h00, exp[7], exp[0]});
   endtask
   task automatic t_nrz();
      conv('{1'b1, 8'h5a}, 1'b0, 9'h0ff);
      conv('{1'b0, 8'h01}, 1'b0, 9'h001);
      $display("nrz done");
   endtask
   task automatic t_rtz();
      conv('{1'b1, 8'h33}, 1'b1, 9'h100);
      conv('{1'b0, 8'h80}, 1'b1, 9'h080);
      $display("rtz done");
   endtask
   // Fill to refusal, then drain; the ninth rise finds the queue empty and publishes the tail
   task automatic t_fill();
      for (int i = 0; i < 8; i++) push('{1'b0, 8'h10 + i[7:0]});
      @(negedge mclk);
      chk({8'h00, s_ready}, 9'h000);
      @(posedge mclk);
      repeat (9) enc();
      chk(cap, 9'h017);
      chk({ovr, dout}, 9'h017);
      $display("fill done");
   endtask
   initial begin
      tick(5);
      nrst <= 1'b1;
      tick(4);
      // Prime: the first rise has no earlier conversion to publish
      enc();
      t_nrz();
      t_rtz();
      t_fill();
      conclude();
   end
endmodule // tb
`default_nettype wire
